// File: logic/rdsc_top.sv
// Register bank for the third small LDO control and the two discharge-control registers.
// Assumes pins are synchronous to ref_clk_i; the board resolves the open-drain data line from sda_oe_o.
`timescale 1ns/1ps
`include "rdsc_defines.svh"

// Notes on behaviour
// - Sleep select 00 always keeps the third small LDO on its normal voltage code.
// - Sleep select 11 applies the sleep code while the assigned sleep pin is low, normal code otherwise.
// - Which of the two sleep pins governs the rail is fixed at configuration time.
// - An enable bit of 0 turns the rail off whatever the control pins say; 1 leaves normal enable control.
// - A discharge field reads and acts as 00 for as long as its rail is enabled.
// - Discharge codes are 00 none, 01 100 ohm, 10 200 ohm and 11 500 ohm.
// - The first discharge register holds controller rails four to one in bits 7:6 down to 1:0.
// - The second holds small LDO two, load switch one, rail six and rail five in bits 7:6 down to 1:0.
// - Control bits 7:6 are read-only, sleep select sits in 5:4 and the enable bit in bit 0.
module rdsc_top #(
	parameter logic [6:0] DEV_ADDR        = `RDSC_DEV_ADDR,
	parameter bit         SLEEP_PIN_TWO   = 1'b0,
	parameter logic [5:0] CTRL_RESET      = `RDSC_CTRL_RESET,
	parameter logic [7:0] DISCH1_RESET    = `RDSC_DISCH_RESET,
	parameter logic [7:0] DISCH2_RESET    = `RDSC_DISCH_RESET,
	parameter int         RAILS           = 8
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_o,
	input  wire logic                       sleep_pin_one_i,
	input  wire logic                       sleep_pin_two_i,
	input  wire logic                       ldo_three_pin_enable_i,
	input  wire logic [RAILS-1:0]           rail_enabled_i,
	output logic                            ldo_three_on_o,
	output logic                            ldo_three_use_sleep_code_o,
	output rdsc_pkg::rdsc_disch_sel_t       discharge_select_o [RAILS]
);
	import rdsc_pkg::*;

	rdsc_wr_t        bus_wr;
	logic [7:0]      rd_addr;
	logic [7:0]      rd_data;
	logic [5:0]      ctrl_q;
	logic            on_q, use_sleep_q;
	logic            sleep_pin;
	logic [1:0]      sleep_select_ldo_three;
	logic            ldo_three_enable_bit;
	rdsc_disch_sel_t disch_sel [RAILS];

	// Serial control bus target
	rdsc_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_bus (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_oe_o  (sda_oe_o),
		.wr_o      (bus_wr),
		.rd_addr_o (rd_addr),
		.rd_data_i (rd_data)
	);

	// Open drain: only ever pulls low
	assign sda_o = 1'b0;

	// Read decode of one discharge register from its four fields
	function automatic logic [7:0] disch_byte(input int base);
		logic [7:0] b;
		b = `RDSC_BYTE_ZERO;
		for (int k = 0; k < `RDSC_FIELDS_PER_REG; k++) begin
			b[k*`RDSC_FIELD_W +: `RDSC_FIELD_W] = disch_sel[base + k];
		end
		return b;
	endfunction : disch_byte

	// Register address decode, used for reads and writes
	function automatic int reg_slot(input logic [7:0] a);
		case (a)
			`RDSC_ADDR_LDO3_CTRL:    reg_slot = 0;
			`RDSC_ADDR_DISCH_FIRST:  reg_slot = 1;
			`RDSC_ADDR_DISCH_SECOND: reg_slot = 2;
			default:                 reg_slot = -1;
		endcase
	endfunction : reg_slot

	// Read data mux; unmapped addresses read zero
	always_comb begin
		case (reg_slot(rd_addr))
			0:       rd_data = {`RDSC_CTRL_RO_VALUE, ctrl_q};
			1:       rd_data = disch_byte(0);
			2:       rd_data = disch_byte(`RDSC_FIELDS_PER_REG);
			default: rd_data = `RDSC_BYTE_ZERO;
		endcase
	end

	// Control register store; bits 7:6 are not stored
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (bus_wr.vld && reg_slot(bus_wr.addr) == 0) begin
			ctrl_q <= bus_wr.data[`RDSC_CTRL_STORE_MSB:0];
		end
	end

	assign sleep_select_ldo_three = ctrl_q[`RDSC_CTRL_SLP_MSB:`RDSC_CTRL_SLP_LSB];
	assign ldo_three_enable_bit   = ctrl_q[`RDSC_CTRL_EN_BIT];

	// Assigned sleep pin fixed by configuration
	assign sleep_pin = SLEEP_PIN_TWO ? sleep_pin_two_i : sleep_pin_one_i;

	// Voltage code selection; only 11 engages sleep, reserved codes act as off
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			use_sleep_q <= 1'b0;
		end else if (sleep_select_ldo_three == `RDSC_SLP_ON) begin
			use_sleep_q <= ~sleep_pin;
		end else begin
			use_sleep_q <= 1'b0;
		end
	end

	// Rail enable: software disable overrides the control pins
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			on_q <= 1'b0;
		end else begin
			on_q <= ldo_three_enable_bit & ldo_three_pin_enable_i;
		end
	end

	assign ldo_three_on_o             = on_q;
	assign ldo_three_use_sleep_code_o = use_sleep_q;

	// Discharge fields: first register rails 0..3, second register rails 4..7
	for (genvar i = 0; i < RAILS; i++) begin : g_field
		localparam int REG_IDX = i / `RDSC_FIELDS_PER_REG;
		localparam int LSB     = (i % `RDSC_FIELDS_PER_REG) * `RDSC_FIELD_W;
		localparam logic [7:0] RST_BYTE = (REG_IDX == 0) ? DISCH1_RESET : DISCH2_RESET;
		logic fld_wr;

		assign fld_wr = bus_wr.vld && (reg_slot(bus_wr.addr) == REG_IDX + 1);

		rdsc_disch_field #(
			.RESET_SEL (RST_BYTE[LSB +: `RDSC_FIELD_W])
		) u_field (
			.ref_clk_i (ref_clk_i),
			.resetn_i  (resetn_i),
			.wr_en_i   (fld_wr),
			.wr_data_i (bus_wr.data[LSB +: `RDSC_FIELD_W]),
			.rail_en_i (rail_enabled_i[i]),
			.sel_o     (disch_sel[i])
		);

		assign discharge_select_o[i] = disch_sel[i];
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_sleep_normal: assert property ((sleep_select_ldo_three == `RDSC_SLP_OFF) |=> !use_sleep_q)
		else $error("sleep code used while sleep select is off");
	chk_sleep_active: assert property (
		(sleep_select_ldo_three == `RDSC_SLP_ON && !sleep_pin) |=> use_sleep_q)
		else $error("sleep code not used with pin low");
	chk_sleep_release: assert property (
		(sleep_select_ldo_three == `RDSC_SLP_ON && sleep_pin) |=> !use_sleep_q)
		else $error("sleep code used with pin high");
	chk_pin_choice: assert property (
		(sleep_select_ldo_three == `RDSC_SLP_ON && $stable(sleep_select_ldo_three))
		|-> use_sleep_q == !$past(SLEEP_PIN_TWO ? sleep_pin_two_i : sleep_pin_one_i))
		else $error("wrong sleep pin governs the rail");
	chk_rail_off: assert property (!ldo_three_enable_bit |=> !on_q [*1])
		else $error("rail on while enable bit is zero");
	chk_rail_follow: assert property (ldo_three_enable_bit |=> on_q == $past(ldo_three_pin_enable_i))
		else $error("rail does not follow control pin enable");
	chk_ctrl_write: assert property ((bus_wr.vld && bus_wr.addr == `RDSC_ADDR_LDO3_CTRL)
		|=> ctrl_q == $past(bus_wr.data[`RDSC_CTRL_STORE_MSB:0]))
		else $error("control register write lost");
	chk_ro_bits: assert property ((rd_addr == `RDSC_ADDR_LDO3_CTRL) |-> rd_data[7:6] == `RDSC_CTRL_RO_VALUE)
		else $error("read-only control bits not zero");
	chk_disch_map: assert property ((bus_wr.vld && bus_wr.addr == `RDSC_ADDR_DISCH_SECOND && !rail_enabled_i[7])
		|=> disch_sel[7] == $past(bus_wr.data[7:6]))
		else $error("second discharge register top field misplaced");
	chk_disch_first: assert property ((bus_wr.vld && bus_wr.addr == `RDSC_ADDR_DISCH_FIRST && !rail_enabled_i[0])
		|=> disch_sel[0] == $past(bus_wr.data[1:0]))
		else $error("first discharge register low field misplaced");
	chk_disch_zero: assert property (rail_enabled_i[3] |=> disch_sel[3] == RDSC_DIS_NONE)
		else $error("enabled rail shows nonzero discharge");

	cov_sleep_used: cover property (use_sleep_q);
	cov_rail_forced_off: cover property (!ldo_three_enable_bit && ldo_three_pin_enable_i);
	cov_disch_cleared: cover property (rail_enabled_i[0] && bus_wr.vld && bus_wr.addr == `RDSC_ADDR_DISCH_FIRST);

endmodule : rdsc_top

// File: logic/rdsc_defines.svh
// Register offsets, field positions, reset values and bus constants of the rail control bank.
// Assumes inclusion by bare name from every file of the bank except the package, which does not include it.
`ifndef RDSC_DEFINES_SVH
`define RDSC_DEFINES_SVH

// Register addresses
`define RDSC_ADDR_LDO3_CTRL    8'h29
`define RDSC_ADDR_DISCH_FIRST  8'h40
`define RDSC_ADDR_DISCH_SECOND 8'h41

// Control register fields
`define RDSC_CTRL_SLP_MSB      5
`define RDSC_CTRL_SLP_LSB      4
`define RDSC_CTRL_EN_BIT       0
`define RDSC_CTRL_STORE_MSB    5
`define RDSC_CTRL_RO_VALUE     2'b00
`define RDSC_CTRL_RESET        6'h0C

// Sleep-select encodings
`define RDSC_SLP_OFF           2'b00
`define RDSC_SLP_ON            2'b11

// Discharge fields
`define RDSC_FIELD_W           2
`define RDSC_FIELDS_PER_REG    4
`define RDSC_DISCH_CLEAR       2'b00
`define RDSC_DISCH_RESET       8'h55

// Serial bus
`define RDSC_DEV_ADDR          7'h5E
`define RDSC_BYTE_BITS         4'd8
`define RDSC_BYTE_ZERO         8'h00

`endif

// File: logic/rdsc_pkg.sv
// Types shared by the rail discharge and sleep control bank.
// Assumes the defines header is compiled alongside.
package rdsc_pkg;

	// Discharge strength selected for one rail
	typedef enum logic [1:0] {
		RDSC_DIS_NONE,
		RDSC_DIS_100R,
		RDSC_DIS_200R,
		RDSC_DIS_500R
	} rdsc_disch_sel_t;

	// Register write request from the serial slave
	typedef struct packed {
		logic       vld;
		logic [7:0] addr;
		logic [7:0] data;
	} rdsc_wr_t;

endpackage : rdsc_pkg

// File: logic/rdsc_disch_field.sv
// One two-bit discharge-select field with its automatic clear.
// Assumes the rail enable is a level synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "rdsc_defines.svh"

module rdsc_disch_field #(
	parameter logic [1:0] RESET_SEL = `RDSC_DISCH_CLEAR
) (
	input  wire logic                     ref_clk_i,
	input  wire logic                     resetn_i,
	input  wire logic                     wr_en_i,
	input  wire logic [1:0]               wr_data_i,
	input  wire logic                     rail_en_i,
	output rdsc_pkg::rdsc_disch_sel_t     sel_o
);
	import rdsc_pkg::*;

	rdsc_disch_sel_t sel_q;

	// Field store; an enabled rail holds the field at none
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_q <= rdsc_disch_sel_t'(RESET_SEL);
		end else if (rail_en_i) begin
			sel_q <= rdsc_disch_sel_t'(`RDSC_DISCH_CLEAR);
		end else if (wr_en_i) begin
			sel_q <= rdsc_disch_sel_t'(wr_data_i);
		end
	end

	assign sel_o = sel_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_field_clear: assert property (rail_en_i |=> sel_q == RDSC_DIS_NONE)
		else $error("discharge field not cleared while rail enabled");
	chk_field_write: assert property ((wr_en_i && !rail_en_i) |=> sel_q == $past(wr_data_i))
		else $error("discharge field did not take written value");

endmodule : rdsc_disch_field

// File: logic/rdsc_i2c_slave.sv
// Serial control bus target: address match, register pointer, auto-incrementing reads and writes.
// Assumes scl_i and sda_i are already synchronous to ref_clk_i and sda is open drain.
`timescale 1ns/1ps
`include "rdsc_defines.svh"

module rdsc_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = `RDSC_DEV_ADDR
) (
	input  wire logic                ref_clk_i,
	input  wire logic                resetn_i,
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output logic                     sda_oe_o,
	output rdsc_pkg::rdsc_wr_t       wr_o,
	output logic [7:0]               rd_addr_o,
	input  wire logic [7:0]          rd_data_i
);
	import rdsc_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} rdsc_i2c_st_t;

	rdsc_i2c_st_t state_q;
	logic         scl_q, sda_q, rw_q, oe_q;
	logic [3:0]   cnt_q;
	logic [7:0]   shift_q, tx_q, ptr_q;
	rdsc_wr_t     wr_q;
	logic         scl_rise, scl_fall, bus_start, bus_stop, byte_done;

	// Bus edge and condition detection
	assign scl_rise  = scl_i & ~scl_q;
	assign scl_fall  = ~scl_i & scl_q;
	assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
	assign bus_stop  = scl_i & scl_q & ~sda_q & sda_i;
	assign byte_done = (cnt_q == `RDSC_BYTE_BITS);

	// Previous line levels
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Protocol sequencing, bit count and line drive
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'd0;
			oe_q    <= 1'b0;
			rw_q    <= 1'b0;
			shift_q <= `RDSC_BYTE_ZERO;
			tx_q    <= `RDSC_BYTE_ZERO;
			ptr_q   <= `RDSC_BYTE_ZERO;
			wr_q    <= '0;
		end else begin
			wr_q.vld <= 1'b0;
			if (bus_start) begin
				state_q <= ST_ADDR;
				cnt_q   <= 4'd0;
				oe_q    <= 1'b0;
			end else if (bus_stop) begin
				state_q <= ST_IDLE;
				oe_q    <= 1'b0;
			end else if (scl_rise) begin
				case (state_q)
					ST_ADDR, ST_PTR, ST_WDATA: begin
						shift_q <= {shift_q[6:0], sda_i};
						cnt_q   <= cnt_q + 4'd1;
					end
					ST_RDATA: cnt_q <= cnt_q + 4'd1;
					ST_RDATA_ACK: begin
						if (sda_i) begin
							state_q <= ST_IDLE; // Controller ends the read
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state_q)
					ST_ADDR: begin
						if (byte_done) begin
							cnt_q <= 4'd0;
							if (shift_q[7:1] == DEV_ADDR) begin
								rw_q    <= shift_q[0];
								oe_q    <= 1'b1;
								state_q <= ST_ADDR_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_PTR: begin
						if (byte_done) begin
							cnt_q   <= 4'd0;
							ptr_q   <= shift_q;
							oe_q    <= 1'b1;
							state_q <= ST_PTR_ACK;
						end
					end
					ST_WDATA: begin
						if (byte_done) begin
							cnt_q   <= 4'd0;
							wr_q    <= '{vld: 1'b1, addr: ptr_q, data: shift_q};
							ptr_q   <= ptr_q + 8'h01;
							oe_q    <= 1'b1;
							state_q <= ST_WDATA_ACK;
						end
					end
					ST_ADDR_ACK, ST_RDATA_ACK: begin
						if (rw_q) begin
							tx_q    <= rd_data_i;
							oe_q    <= ~rd_data_i[7];
							ptr_q   <= ptr_q + 8'h01;
							cnt_q   <= 4'd0;
							state_q <= ST_RDATA;
						end else begin
							oe_q    <= 1'b0;
							state_q <= ST_PTR;
						end
					end
					ST_PTR_ACK, ST_WDATA_ACK: begin
						oe_q    <= 1'b0;
						state_q <= ST_WDATA;
					end
					ST_RDATA: begin
						if (byte_done) begin
							oe_q    <= 1'b0;
							cnt_q   <= 4'd0;
							state_q <= ST_RDATA_ACK;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							oe_q <= ~tx_q[6];
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign sda_oe_o  = oe_q;
	assign wr_o      = wr_q;
	assign rd_addr_o = ptr_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_wr_single: assert property (wr_q.vld |=> !wr_q.vld)
		else $error("register write strobe longer than one cycle");
	chk_ack_drive: assert property ((state_q == ST_PTR_ACK) |-> oe_q)
		else $error("pointer byte not acknowledged");
	cov_write_seen: cover property (wr_q.vld);
	cov_read_seen: cover property (state_q == ST_RDATA_ACK);

endmodule : rdsc_i2c_slave

// File: verif/rdsc_i2c_host.sv
// Serial bus controller model that reaches the rail control bank registers.
// Assumes a pull-up on the data line; the bench resolves the wire from the host enable and both target enables.
`timescale 1ns/1ps
`include "rdsc_defines.svh"

module rdsc_i2c_host (
	input  wire logic        ref_clk_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             sda_oe_o,
	output logic             rd_vld_o,
	output logic [7:0]       rd_byte_o,
	output logic             ack_o
);
	// Idle bus: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
		rd_vld_o = 1'b0;
		rd_byte_o = 8'h00;
		ack_o = 1'b0;
	end

	// Quarter bit: four reference cycles, changes at the falling edge
	task automatic half;
		repeat (4) @(negedge ref_clk_i);
	endtask : half

	// One bit: data set while clock low, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		half;
		sda_oe_o = ~b;
		half;
		scl_o = 1'b1;
		half;
		s = sda_i;
		half;
		scl_o = 1'b0;
	endtask : bit_io

	// Start, also serves as repeated start from clock low
	task automatic start;
		half;
		sda_oe_o = 1'b0;
		half;
		scl_o = 1'b1;
		half;
		sda_oe_o = 1'b1;
		half;
		scl_o = 1'b0;
	endtask : start

	task automatic stop;
		half;
		sda_oe_o = 1'b1;
		half;
		scl_o = 1'b1;
		half;
		sda_oe_o = 1'b0;
		half;
	endtask : stop

	// Byte out MSB first, then the target's acknowledge
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack_o = ~s;
	endtask : send_byte

	// Byte in MSB first, then a NACK to end the read
	task automatic read_byte;
		logic s;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(1'b1, s);
		rd_byte_o = d;
		rd_vld_o = 1'b1;
		@(negedge ref_clk_i);
		rd_vld_o = 1'b0;
	endtask : read_byte

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start;
		send_byte({`RDSC_DEV_ADDR, 1'b0});
		send_byte(a);
		send_byte(d);
		stop;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		start;
		send_byte({`RDSC_DEV_ADDR, 1'b0});
		send_byte(a);
		start;
		send_byte({`RDSC_DEV_ADDR, 1'b1});
		read_byte;
		stop;
	endtask : rd
endmodule : rdsc_i2c_host

// File: verif/tb_top.sv
// Self-checking bench for the rail control bank: registers, sleep and enable outputs, discharge clear.
// Assumes the bank's defaults, eight rails and reset bytes from the defines header; a second copy on the same
// bus is built with sleep pin two assigned, so both pin choices are exercised.
`timescale 1ns/1ps
`include "rdsc_defines.svh"

module tb_top;
	import rdsc_pkg::*;
	typedef struct { string name; int kind; logic [7:0] exp; } rdsc_note_t;
	logic            ref_clk, resetn, scl, host_oe, dut_oe, sda_o_w, pin1, pin2, pen, on, slp, probe;
	logic            rd_vld, ack, dut2_oe, on2, slp2;
	logic [7:0]      rd_byte, rails, m, v, b1;
	wire             sda = ~(host_oe | dut_oe | dut2_oe);
	rdsc_disch_sel_t disch [8];
	rdsc_note_t      notes [$];
	rdsc_note_t      n;
	logic [7:0]      seen;
	int              n_errors, n_checks, cycles;
	logic [7:0]      ctrl_vals [3] = '{8'hFD, 8'h0D, 8'h3C};

	rdsc_top i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o_w),
		.sda_oe_o(dut_oe), .sleep_pin_one_i(pin1), .sleep_pin_two_i(pin2), .ldo_three_pin_enable_i(pen),
		.rail_enabled_i(rails), .ldo_three_on_o(on), .ldo_three_use_sleep_code_o(slp),
		.discharge_select_o(disch));
	// Same bus and pins, sleep governed by pin two
	rdsc_top #(.SLEEP_PIN_TWO(1'b1)) i_dut_two (.ref_clk_i(ref_clk), .resetn_i(resetn), .scl_i(scl),
		.sda_i(sda), .sda_o(), .sda_oe_o(dut2_oe), .sleep_pin_one_i(pin1), .sleep_pin_two_i(pin2),
		.ldo_three_pin_enable_i(pen), .rail_enabled_i(rails), .ldo_three_on_o(on2),
		.ldo_three_use_sleep_code_o(slp2), .discharge_select_o());
	rdsc_i2c_host i_host (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe),
		.rd_vld_o(rd_vld), .rd_byte_o(rd_byte), .ack_o(ack));

	// Clock, 5 ns period
	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;

	// Watcher: oldest note against whatever result shows up
	always @(posedge ref_clk) begin
		if (rd_vld || probe) begin
			n = notes.pop_front();
			case (n.kind)
				0: seen = rd_byte;
				1: seen = {4'h0, on2, slp2, on, slp};
				2: seen = {disch[3], disch[2], disch[1], disch[0]};
				3: seen = {disch[7], disch[6], disch[5], disch[4]};
				default: seen = {6'h00, sda_o_w, ack};
			endcase
			n_checks++;
			if (seen !== n.exp) begin
				n_errors++;
				$display("[FAIL] %s expected %h seen %h", n.name, n.exp, seen);
			end
		end
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			$display("[FAIL] run length expected under 90000 seen 90000");
			end_of_test;
		end
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic expect_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		notes.push_back('{nm, 0, e});
		i_host.rd(a);
	endtask : expect_rd

	task automatic probe_port(input string nm, input int k, input logic [7:0] e);
		notes.push_back('{nm, k, e});
		probe = 1'b1;
		@(negedge ref_clk);
		probe = 1'b0;
		@(negedge ref_clk);
	endtask : probe_port

	// Fields of enabled rails forced to none
	function automatic logic [7:0] clr(input logic [7:0] b, input logic [3:0] msk);
		for (int i = 0; i < 4; i++) if (msk[i]) b[2*i +: 2] = 2'b00;
		return b;
	endfunction : clr

	task automatic check_reset;
		probe_port("ldo outputs at reset", 1, 8'h00);
		expect_rd("ctrl reset", `RDSC_ADDR_LDO3_CTRL, {2'b00, `RDSC_CTRL_RESET});
	endtask : check_reset

	// Main sequence
	initial begin
		{resetn, pin1, pin2, pen, probe, rails} = 13'h0E00;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		void'($urandom(11));
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
		@(negedge ref_clk);
		check_reset;
		expect_rd("disch1 reset", `RDSC_ADDR_DISCH_FIRST, `RDSC_DISCH_RESET);
		expect_rd("disch2 reset", `RDSC_ADDR_DISCH_SECOND, `RDSC_DISCH_RESET);
		i_host.wr(8'h30, 8'hA5);
		expect_rd("unmapped read", 8'h30, 8'h00);
		i_host.start;
		i_host.send_byte({`RDSC_DEV_ADDR ^ 7'h01, 1'b0});
		i_host.stop;
		probe_port("foreign address ack", 4, 8'h00);
		// Control register settings against random pin levels
		foreach (ctrl_vals[c]) begin
			v = ctrl_vals[c];
			i_host.wr(`RDSC_ADDR_LDO3_CTRL, v);
			probe_port("write ack", 4, 8'h01);
			expect_rd("ctrl readback", `RDSC_ADDR_LDO3_CTRL, v & 8'h3F);
			for (int j = 0; j < 6; j++) begin
				{pin1, pin2, pen} = 3'($urandom);
				repeat (2) @(negedge ref_clk);
				probe_port("ldo outputs", 1, {4'h0, v[0] & pen, (v[5:4] == 2'b11) & ~pin2,
					v[0] & pen, (v[5:4] == 2'b11) & ~pin1});
			end
		end
		// Every code in each register, fixed then random patterns
		for (int p = 0; p < 4; p++) begin
			b1 = (p == 0) ? 8'hE4 : (p == 1) ? 8'h1B : 8'($urandom);
			i_host.wr(`RDSC_ADDR_DISCH_FIRST, b1);
			i_host.wr(`RDSC_ADDR_DISCH_SECOND, ~b1);
			expect_rd("disch1 readback", `RDSC_ADDR_DISCH_FIRST, b1);
			expect_rd("disch2 readback", `RDSC_ADDR_DISCH_SECOND, ~b1);
			probe_port("disch low rails", 2, b1);
			probe_port("disch high rails", 3, ~b1);
		end
		// Enabled rails clear their fields and refuse writes
		for (int k = 0; k < 2; k++) begin
			m = k ? 8'hFF : 8'($urandom);
			i_host.wr(`RDSC_ADDR_DISCH_FIRST, 8'hFF);
			i_host.wr(`RDSC_ADDR_DISCH_SECOND, 8'hFF);
			rails = m;
			repeat (2) @(negedge ref_clk);
			probe_port("cleared low", 2, clr(8'hFF, m[3:0]));
			probe_port("cleared high", 3, clr(8'hFF, m[7:4]));
			i_host.wr(`RDSC_ADDR_DISCH_FIRST, 8'hAA);
			i_host.wr(`RDSC_ADDR_DISCH_SECOND, 8'hAA);
			expect_rd("disch1 while enabled", `RDSC_ADDR_DISCH_FIRST, clr(8'hAA, m[3:0]));
			expect_rd("disch2 while enabled", `RDSC_ADDR_DISCH_SECOND, clr(8'hAA, m[7:4]));
			rails = 8'h00;
			repeat (2) @(negedge ref_clk);
			probe_port("held low", 2, clr(8'hAA, m[3:0]));
			probe_port("held high", 3, clr(8'hAA, m[7:4]));
		end
		// Second reset in mid-run
		resetn = 1'b0;
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		@(negedge ref_clk);
		check_reset;
		end_of_test;
	end
endmodule : tb_top
